/* File: src/sam_regs.vh */
// Constants for the slave address and remote bit mapper.
// Assumes inclusion by bare name from design files on a 25 MHz clock.
`ifndef SAM_REGS_VH
`define SAM_REGS_VH

// ---------------------------------------------------------------------
// Address space
// ---------------------------------------------------------------------
`define SAM_ADDR_MAX        8'hFE
`define SAM_ADDR_NOID       8'hFF
`define SAM_ADDR_RESET      8'hFF
`define SAM_ID_IN_OFFSET    10'h0200
`define SAM_WORD_LSB        4
`define SAM_BIT_W           4

// ---------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------
`define SAM_CLK_HZ          25000000
`define SAM_HOLDOFF_MS      5000
// Five seconds at the 25 MHz clock, sized to the hold-off counter
`define SAM_HOLDOFF_CYC     28'h773_5940

`endif

/* File: src/sam_holdoff.v */
// Power-up / bus-reset hold-off timer for parameter writes.
// Assumes busReset is already synchronous to clk_sys.
`timescale 1ns/1ps
`include "sam_regs.vh"

module sam_holdoff #(
    parameter [27:0] HOLD_CYC = `SAM_HOLDOFF_CYC
) (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        busReset,
    output reg         holdActive_r
);
    reg [27:0] cnt_r;

    // Restarts on device reset or on a bus reset
    always @(posedge clk_sys) begin
        if (!resetn || busReset) begin
            cnt_r        <= 28'h000_0000;
            holdActive_r <= 1'b1;
        end else if (cnt_r >= HOLD_CYC - 28'h000_0001) begin
            holdActive_r <= 1'b0;
        end else begin
            cnt_r        <= cnt_r + 28'h000_0001;
            holdActive_r <= 1'b1;
        end
    end
endmodule // sam_holdoff

/* File: src/sam_mapper.v */
// Slave address store, identifier derivation and remote bit mapping.
// Assumes the tool link delivers decoded write/read strobes from pins.
`timescale 1ns/1ps
`include "sam_regs.vh"

module sam_mapper #(
    parameter [27:0] HOLD_CYC = `SAM_HOLDOFF_CYC
) (
    input  wire        clk_sys,
    input  wire        resetn,
    input  wire        irAddrWrite,
    input  wire [7:0]  irAddrData,
    input  wire        irAddrRead,
    input  wire        irParamWrite,
    input  wire        isInputSlave,
    input  wire [3:0]  slavePoints,
    input  wire [7:0]  nvAddr,
    input  wire        busError,
    input  wire        busReset,
    input  wire        detectStart,
    input  wire        detectDone,
    output reg  [7:0]  nvAddrWr_r,
    output reg         nvWrite_r,
    output reg  [7:0]  irAddrReadData_r,
    output reg         irAddrReadValid_r,
    output reg         irAddrReject_r,
    output reg         paramAccept_r,
    output reg         paramReject_r,
    output reg         missingIdentifierError_r,
    output reg  [9:0]  busId_r,
    output reg         outputAreaSel_r,
    output reg         inputAreaSel_r,
    output reg  [3:0]  wordIndex_r,
    output reg  [3:0]  bitIndex_r,
    output reg  [8:0]  lastBit_r,
    output reg         detectActive_r
);
    // -----------------------------------------------------------------
    // Input synchronisers
    // -----------------------------------------------------------------
    reg [10:0] sync1_r;
    reg [10:0] sync2_r;
    reg [7:0]  dataS1_r;
    reg [7:0]  dataS2_r;
    reg [3:0]  ptsS1_r;
    reg [3:0]  ptsS2_r;
    reg [10:0] prev_r;
    wire       holdActive;

    always @(posedge clk_sys) begin
        if (!resetn) begin
            sync1_r  <= 11'h000;
            sync2_r  <= 11'h000;
            dataS1_r <= 8'h00;
            dataS2_r <= 8'h00;
            ptsS1_r  <= 4'h0;
            ptsS2_r  <= 4'h0;
            prev_r   <= 11'h000;
        end else begin
            sync1_r  <= {irAddrWrite, irAddrRead, irParamWrite, isInputSlave, busError,
                         busReset, detectStart, detectDone, 3'b000};
            sync2_r  <= sync1_r;
            dataS1_r <= irAddrData;
            dataS2_r <= dataS1_r;
            ptsS1_r  <= slavePoints;
            ptsS2_r  <= ptsS1_r;
            prev_r   <= sync2_r;
        end
    end

    wire addrWrS  = sync2_r[10];
    wire addrRdS  = sync2_r[9];
    wire paramWrS = sync2_r[8];
    wire inputS   = sync2_r[7];
    wire busErrS  = sync2_r[6];
    wire busRstS  = sync2_r[5];
    wire detStS   = sync2_r[4];
    wire detDnS   = sync2_r[3];
    wire addrWrP  = addrWrS & ~prev_r[10];
    wire addrRdP  = addrRdS & ~prev_r[9];
    wire paramWrP = paramWrS & ~prev_r[8];
    wire busRstP  = busRstS & ~prev_r[5];

    // -----------------------------------------------------------------
    // Hold-off after power-on or bus reset
    // -----------------------------------------------------------------
    sam_holdoff #(
        .HOLD_CYC     (HOLD_CYC)
    ) uHold (
        .clk_sys      (clk_sys),
        .resetn       (resetn),
        .busReset     (busRstP),
        .holdActive_r (holdActive)
    );

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function [9:0] idOf;
        input [7:0] a;
        input       isIn;
        begin
            idOf = isIn ? ({2'b00, a} + `SAM_ID_IN_OFFSET) : {2'b00, a};
        end
    endfunction

    function hasId;
        input [7:0] a;
        begin
            hasId = (a != `SAM_ADDR_NOID);
        end
    endfunction

    function [8:0] lastOf;
        input [7:0] a;
        input [3:0] n;
        begin
            lastOf = {1'b0, a} + {5'h00, n} - 9'h001;
        end
    endfunction

    // -----------------------------------------------------------------
    // Address store and tool link
    // -----------------------------------------------------------------
    reg [7:0] addr_r;
    reg       addrLoaded_r;
    wire      addrOk = (dataS2_r <= `SAM_ADDR_MAX);

    always @(posedge clk_sys) begin
        if (!resetn) begin
            addr_r            <= `SAM_ADDR_RESET;
            addrLoaded_r      <= 1'b0;
            nvAddrWr_r        <= 8'h00;
            nvWrite_r         <= 1'b0;
            irAddrReadData_r  <= 8'h00;
            irAddrReadValid_r <= 1'b0;
            irAddrReject_r    <= 1'b0;
        end else begin
            nvWrite_r         <= 1'b0;
            irAddrReadValid_r <= 1'b0;
            irAddrReject_r    <= 1'b0;
            if (!addrLoaded_r) begin
                addr_r       <= nvAddr;
                addrLoaded_r <= 1'b1;
            end else if (addrWrP) begin
                if (addrOk) begin
                    addr_r     <= dataS2_r;
                    nvAddrWr_r <= dataS2_r;
                    nvWrite_r  <= 1'b1;
                end else begin
                    irAddrReject_r <= 1'b1;
                end
            end
            if (addrRdP) begin
                irAddrReadData_r  <= addr_r;
                irAddrReadValid_r <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Detection flag and parameter gating
    // -----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn) begin
            detectActive_r <= 1'b0;
            paramAccept_r  <= 1'b0;
            paramReject_r  <= 1'b0;
        end else begin
            if (detStS)
                detectActive_r <= 1'b1;
            else if (detDnS)
                detectActive_r <= 1'b0;
            paramAccept_r <= 1'b0;
            paramReject_r <= 1'b0;
            if (paramWrP) begin
                if (busErrS || holdActive || detectActive_r)
                    paramReject_r <= 1'b1;
                else
                    paramAccept_r <= 1'b1;
            end
        end
    end

    // -----------------------------------------------------------------
    // Identifier and remote bit mapping
    // -----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!resetn) begin
            missingIdentifierError_r <= 1'b0;
            busId_r         <= 10'h000;
            outputAreaSel_r <= 1'b0;
            inputAreaSel_r  <= 1'b0;
            wordIndex_r     <= 4'h0;
            bitIndex_r      <= 4'h0;
            lastBit_r       <= 9'h000;
        end else begin
            missingIdentifierError_r <= !hasId(addr_r);
            busId_r         <= idOf(addr_r, inputS);
            outputAreaSel_r <= hasId(addr_r) && !inputS;
            inputAreaSel_r  <= hasId(addr_r) && inputS;
            wordIndex_r     <= addr_r[7:`SAM_WORD_LSB];
            bitIndex_r      <= addr_r[`SAM_WORD_LSB-1:0];
            lastBit_r       <= lastOf(addr_r, ptsS2_r);
        end
    end
endmodule // sam_mapper

/* File: verification/sam_nv_model.sv */
// Nonvolatile address store standing behind the mapper.
// Assumes nvWrite_r is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps
module sam_nv_model (
    input  wire logic       clk_sys,
    input  wire logic       nvWrite_r,
    input  wire logic [7:0] nvAddrWr_r,
    output logic      [7:0] nvAddr
);
    initial nvAddr = 8'h0C;
    // Kept across resets, changed by writes only
    always @(posedge clk_sys) if (nvWrite_r) nvAddr <= nvAddrWr_r;
endmodule // sam_nv_model

/* File: verification/sam_mapper_properties.sv */
// Concurrent checks on the mapper ports.
// Assumes binding onto sam_mapper, one clock domain.
`timescale 1ns/1ps
module sam_mapper_props (
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       nvWrite_r,
    input wire logic [7:0] nvAddrWr_r,
    input wire logic       busError,
    input wire logic       detectStart,
    input wire logic       detectActive_r,
    input wire logic       paramAccept_r,
    input wire logic       paramReject_r,
    input wire logic       missingIdentifierError_r,
    input wire logic       outputAreaSel_r,
    input wire logic       inputAreaSel_r,
    input wire logic [9:0] busId_r,
    input wire logic [3:0] wordIndex_r,
    input wire logic [3:0] bitIndex_r
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    AST_WR_RANGE: assert property (nvWrite_r |-> nvAddrWr_r <= 8'hFE)
        else $error("stored address out of range");
    AST_NO_ID: assert property (
        missingIdentifierError_r |-> !outputAreaSel_r && !inputAreaSel_r)
        else $error("area selected without identifier");
    AST_ID_OUT: assert property (outputAreaSel_r |-> busId_r[9:8] == 2'h0)
        else $error("output id offset wrong");
    AST_ID_IN: assert property (inputAreaSel_r |-> busId_r[9:8] == 2'h2)
        else $error("input id offset wrong");
    AST_AREA: assert property (outputAreaSel_r |-> !inputAreaSel_r)
        else $error("both areas selected");
    AST_INDEX: assert property (
        outputAreaSel_r || inputAreaSel_r |-> {wordIndex_r, bitIndex_r} == busId_r[7:0])
        else $error("word or bit index wrong");
    AST_ERR_REJ: assert property (busError [*8] |-> !paramAccept_r)
        else $error("parameter accepted during bus error");
    AST_DET_REJ: assert property (detectActive_r [*2] |-> !paramAccept_r)
        else $error("parameter accepted during detection");
    AST_HOLDOFF: assert property ($rose(resetn) |-> !paramAccept_r [*8])
        else $error("parameter accepted right after reset");
    AST_DET_FLAG: assert property (detectStart [*5] |-> detectActive_r)
        else $error("detection flag low while running");
    AST_PULSE: assert property (paramAccept_r |-> !paramReject_r ##1 !paramAccept_r)
        else $error("accept pulse malformed");
endmodule // sam_mapper_props
bind sam_mapper sam_mapper_props u_props (.*);

/* File: verification/sam_mapper_tb.sv */
// Self-checking bench for the slave address mapper.
// Assumes the checker binds itself; pins change at falling edge.
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module sam_mapper_tb;
    localparam logic [12:0] W = 13'h1000, RJ = 13'h0800, RD = 13'h0400;
    localparam logic [12:0] AC = 13'h0200, PR = 13'h0100;
    logic clk_sys = 0, resetn = 0, isInputSlave = 0, busError = 0, busReset = 0;
    logic detectStart = 0, detectDone = 0, nvWrite_r, irAddrReadValid_r, irAddrReject_r;
    logic paramAccept_r, paramReject_r, missingIdentifierError_r, detectActive_r;
    logic outputAreaSel_r, inputAreaSel_r;
    logic [2:0] pins = 0;
    logic [3:0] slavePoints = 1, wordIndex_r, bitIndex_r;
    logic [7:0] irAddrData = 0, nvAddr, nvAddrWr_r, irAddrReadData_r, a;
    logic [8:0] lastBit_r;
    logic [9:0] busId_r;
    logic [12:0] exp_q[$];
    logic [31:0] seed = 32'h3ad5, r;
    int num_errors = 0, comparisons = 0, cyc = 0;
    always #20 clk_sys = ~clk_sys;
    sam_mapper #(.HOLD_CYC(28'h000_0014)) dut (.irAddrWrite(pins[0]), .irAddrRead(pins[1]),
        .irParamWrite(pins[2]), .*);
    sam_nv_model u_nv (.*);
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic close_out();
        `CHK("pending answers", 0, exp_q.size())
        $display("Checks %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic req(input int p, input logic [7:0] d, input logic [12:0] e);
        irAddrData = d;
        repeat (4) @(negedge clk_sys);
        exp_q.push_back(e);
        pins[p] = 1;
        repeat (2) @(negedge clk_sys);
        pins[p] = 0;
        repeat (6) @(negedge clk_sys);
    endtask
    task automatic restart();
        resetn = 0;
        repeat (4) @(negedge clk_sys);
        resetn = 1;
        repeat (4) @(negedge clk_sys);
    endtask
    always @(negedge clk_sys) begin : mon
        logic [12:0] e, g;
        g = {nvWrite_r, irAddrReject_r, irAddrReadValid_r, paramAccept_r, paramReject_r,
             nvWrite_r ? nvAddrWr_r : irAddrReadValid_r ? irAddrReadData_r : 8'h00};
        if (resetn && g[12:8] != 0) begin
            e = exp_q.size() ? exp_q.pop_front() : 13'h0;
            `CHK("tool answer", e, g)
        end
    end
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            close_out();
        end
    end
    initial begin
        repeat (4) @(negedge clk_sys);
        resetn = 1;
        req(2, 0, PR);
        repeat (30) @(negedge clk_sys);
        req(2, 0, AC);
        busError = 1;
        req(2, 0, PR);
        busError = 0;
        detectStart = 1;
        req(2, 0, PR);
        `CHK("detect flag", 1'b1, detectActive_r)
        detectStart = 0;
        detectDone = 1;
        repeat (6) @(negedge clk_sys);
        `CHK("detect flag", 1'b0, detectActive_r)
        detectDone = 0;
        busReset = 1;
        repeat (2) @(negedge clk_sys);
        busReset = 0;
        req(2, 0, PR);
        repeat (30) @(negedge clk_sys);
        // One slave on the bus at a time, so no two ever share a bit
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            a = i == 0 ? 8'h00 : i == 1 ? 8'hFE : r[7:0] % 8'hFF;
            isInputSlave = r[8];
            // Occupied bits stay inside a 256-point transmission area
            slavePoints = a > 8'hF0 ? 4'h1 : r[12:9] % 4'hF + 4'h1;
            req(0, a, W | a);
            req(1, 0, RD | a);
            `CHK("bus id", isInputSlave ? 10'h0200 + a : {2'h0, a}, busId_r)
            `CHK("areas", {!isInputSlave, isInputSlave}, {outputAreaSel_r, inputAreaSel_r})
            `CHK("id present", 1'b0, missingIdentifierError_r)
            `CHK("word and bit", a, {wordIndex_r, bitIndex_r})
            `CHK("last bit", {1'b0, a} + slavePoints - 9'h1, lastBit_r)
        end
        req(0, 8'hFF, RJ);
        req(1, 0, RD | a);
        restart();
        `CHK("kept id", isInputSlave ? 10'h0200 + a : {2'h0, a}, busId_r)
        u_nv.nvAddr = 8'hFF;
        restart();
        `CHK("missing id", 1'b1, missingIdentifierError_r)
        `CHK("no area", 2'h0, {outputAreaSel_r, inputAreaSel_r})
        close_out();
    end
endmodule // sam_mapper_tb
